/* hw/dbc_config_regs.sv */
/*
 * dbc_config_regs: buffer posting, row type and dram mode registers of
 * the host bridge memory controller, reached over an ahb-lite slave.
 * assumes one 20 MHz clock, a single master, word transfers only and
 * request strobes from logic on the same clock; the bridge hold
 * acknowledge arrives from a pin and is synchronised here.
 */
`timescale 1ns/1ps

// How it works
// - ide writes posted only when enabled
// - wc writes posted during bridge hold only when enabled
// - two row type bits per row, row0 lowest
// - 00 edo, 10 sdram, 11 empty, 01 reserved
// - row type looked up before each cycle
// - edo detect bit selects special probe timing
// - sdram power management only while enabled
// - rate 000 off, 001 normal, reset normal
// - normal interval chosen by chipset config bit
// - refresh off issues no requests
// - changing rate restarts the refresh timer
// - timings counted in host clock cycles
module dbc_config_regs (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // host write path
    input wire logic ideWrReq,
    input wire logic wcWrReq,
    output logic idePosted,
    output logic ideNonPosted,
    output logic wcPosted,
    output logic wcHeld,
    // i/o bridge arbitration pin
    input wire logic bridgeHoldAck_n,
    // dram sequencer
    input wire logic cycleReq,
    input wire logic [2:0] cycleRow,
    output logic cycleGo,
    output logic [1:0] cycleType,
    output logic edoProbe,
    output logic sdramPmActive,
    output logic refreshReq
);
    localparam logic [11:0] BUF_ADDR =
        dbc_pkg::byteAddr(dbc_pkg::BUF_CTRL_IDX);
    localparam logic [11:0] ROW_ADDR =
        dbc_pkg::byteAddr(dbc_pkg::ROW_TYPE_IDX);
    localparam logic [11:0] MODE_ADDR =
        dbc_pkg::byteAddr(dbc_pkg::MODE_CTRL_IDX);
    localparam logic [11:0] CFG_ADDR =
        dbc_pkg::byteAddr(dbc_pkg::CHIP_CFG_IDX);
    localparam logic [11:0] STAT_ADDR = dbc_pkg::byteAddr(dbc_pkg::STATUS_IDX);

    // pin synchroniser
    logic [1:0] holdSync_q, holdSync_d;
    logic bridgeHeld;
    // configuration registers
    logic [7:0] bufCtrl_q, bufCtrl_d;
    logic [15:0] rowMap_q, rowMap_d;
    logic [7:0] modeCtrl_q, modeCtrl_d;
    logic [15:0] chipCfg_q, chipCfg_d;
    logic rateRestart_q, rateRestart_d;
    // bus state
    logic addrValid;
    logic wrPend_q, wrPend_d;
    logic [11:0] wrAddr_q, wrAddr_d;
    logic [31:0] rdData_q, rdData_d;
    logic ready_q, resp_q;
    // host side
    logic idePost_q, idePost_d, ideNp_q, ideNp_d;
    logic wcPost_q, wcPost_d, wcHeld_q, wcHeld_d;
    logic pm_q, pm_d;
    logic [7:0] refreshCnt_q, refreshCnt_d;
    dbc_pkg::dbc_row_type_t rowType;

    dbc_refresh_if tmr ();

    // only the second stage is read
    always_comb begin
        holdSync_d = {holdSync_q[0], bridgeHoldAck_n};
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            holdSync_q <= 2'h3;
        end else begin
            holdSync_q <= holdSync_d;
        end
    end

    assign bridgeHeld = !holdSync_q[1];

    // register writes land in the data phase
    always_comb begin
        bufCtrl_d = bufCtrl_q;
        rowMap_d = rowMap_q;
        modeCtrl_d = modeCtrl_q;
        chipCfg_d = chipCfg_q;
        rateRestart_d = 1'b0;
        if (wrPend_q) begin
            if (wrAddr_q == BUF_ADDR) begin
                bufCtrl_d = (bufCtrl_q & ~dbc_pkg::BUF_CTRL_WMASK)
                    | (hwdata[7:0] & dbc_pkg::BUF_CTRL_WMASK);
            end else if (wrAddr_q == ROW_ADDR) begin
                // whole map taken at once; reserved codes are not filtered
                rowMap_d = hwdata[15:0];
            end else if (wrAddr_q == MODE_ADDR) begin
                modeCtrl_d = (modeCtrl_q & ~dbc_pkg::MODE_CTRL_WMASK)
                    | (hwdata[7:0] & dbc_pkg::MODE_CTRL_WMASK);
                rateRestart_d = hwdata[2:0] != modeCtrl_q[2:0];
            end else if (wrAddr_q == CFG_ADDR) begin
                chipCfg_d = hwdata[15:0];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            bufCtrl_q <= dbc_pkg::BUF_CTRL_RST;
            rowMap_q <= dbc_pkg::ROW_TYPE_RST;
            modeCtrl_q <= dbc_pkg::MODE_CTRL_RST;
            chipCfg_q <= dbc_pkg::CHIP_CFG_RST;
            rateRestart_q <= 1'b0;
        end else begin
            bufCtrl_q <= bufCtrl_d;
            rowMap_q <= rowMap_d;
            modeCtrl_q <= modeCtrl_d;
            chipCfg_q <= chipCfg_d;
            rateRestart_q <= rateRestart_d;
        end
    end

    // read data is taken from next values so a read right after a
    // write returns the new contents; unmapped addresses read zero
    always_comb begin
        addrValid = hsel && hready && htrans[1];
        wrPend_d = addrValid && hwrite;
        wrAddr_d = addrValid ? haddr[11:0] : wrAddr_q;
        rdData_d = rdData_q;
        if (addrValid && !hwrite) begin
            rdData_d = 32'h0000_0000;
            if (haddr[11:0] == BUF_ADDR) begin
                rdData_d[7:0] = bufCtrl_d;
            end else if (haddr[11:0] == ROW_ADDR) begin
                rdData_d[15:0] = rowMap_d;
            end else if (haddr[11:0] == MODE_ADDR) begin
                rdData_d[7:0] = modeCtrl_d;
            end else if (haddr[11:0] == CFG_ADDR) begin
                rdData_d[15:0] = chipCfg_d;
            end else if (haddr[11:0] == STAT_ADDR) begin
                rdData_d[15:0] = {refreshCnt_d, 6'h00, bridgeHeld, tmr.run};
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wrPend_q <= 1'b0;
            wrAddr_q <= 12'h000;
            rdData_q <= 32'h0000_0000;
            ready_q <= 1'b1;
            resp_q <= 1'b0;
        end else begin
            wrPend_q <= wrPend_d;
            wrAddr_q <= wrAddr_d;
            rdData_q <= rdData_d;
            ready_q <= 1'b1;
            resp_q <= 1'b0;
        end
    end

    assign hreadyout = ready_q;
    assign hrdata = rdData_q;
    assign hresp = resp_q;

    // posting decisions and dram mode outputs
    always_comb begin
        idePost_d = ideWrReq && bufCtrl_q[dbc_pkg::IDE_POST_BIT];
        ideNp_d = ideWrReq && !bufCtrl_q[dbc_pkg::IDE_POST_BIT];
        wcPost_d = wcWrReq
            && (!bridgeHeld || bufCtrl_q[dbc_pkg::WC_HOLD_BIT]);
        wcHeld_d = wcWrReq && bridgeHeld
            && !bufCtrl_q[dbc_pkg::WC_HOLD_BIT];
        pm_d = modeCtrl_q[dbc_pkg::SDRAM_PM_BIT];
        refreshCnt_d = refreshCnt_q + {7'h00, tmr.req};
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            idePost_q <= 1'b0;
            ideNp_q <= 1'b0;
            wcPost_q <= 1'b0;
            wcHeld_q <= 1'b0;
            pm_q <= 1'b0;
            refreshCnt_q <= 8'h00;
        end else begin
            idePost_q <= idePost_d;
            ideNp_q <= ideNp_d;
            wcPost_q <= wcPost_d;
            wcHeld_q <= wcHeld_d;
            pm_q <= pm_d;
            refreshCnt_q <= refreshCnt_d;
        end
    end

    assign idePosted = idePost_q;
    assign ideNonPosted = ideNp_q;
    assign wcPosted = wcPost_q;
    assign wcHeld = wcHeld_q;
    assign sdramPmActive = pm_q;
    assign refreshReq = tmr.req;

    // reserved rate codes simply stop the timer
    assign tmr.run = modeCtrl_q[2:0] == dbc_pkg::RATE_NORMAL;
    assign tmr.longSel = chipCfg_q[dbc_pkg::LONG_INTERVAL_BIT];
    assign tmr.restart = rateRestart_q;

    dbc_refresh_timer u_timer (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .tmr(tmr)
    );

    dbc_row_lookup u_lookup (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .rowMap(rowMap_q),
        .edoDetect(modeCtrl_q[dbc_pkg::EDO_DETECT_BIT]),
        .cycleReq(cycleReq),
        .cycleRow(cycleRow),
        .cycleGo(cycleGo),
        .cycleType(rowType),
        .edoProbe(edoProbe)
    );

    assign cycleType = rowType;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_rate_change;
        wrPend_q && wrAddr_q == MODE_ADDR
            && hwdata[2:0] != modeCtrl_q[2:0];
    endsequence

    a_ide_posted: assert property (
        ideWrReq && bufCtrl_q[dbc_pkg::IDE_POST_BIT]
        |=> idePosted && !ideNonPosted)
        else $error("ide write not posted while enabled");
    a_ide_nonposted: assert property (
        ideWrReq && !bufCtrl_q[dbc_pkg::IDE_POST_BIT]
        |=> ideNonPosted && !idePosted)
        else $error("ide write posted while disabled");
    a_wc_hold_post: assert property (
        wcWrReq && bridgeHeld && bufCtrl_q[dbc_pkg::WC_HOLD_BIT]
        |=> wcPosted && !wcHeld)
        else $error("wc write stalled despite hold posting");
    a_wc_hold_stall: assert property (
        wcWrReq && bridgeHeld && !bufCtrl_q[dbc_pkg::WC_HOLD_BIT]
        |=> wcHeld && !wcPosted)
        else $error("wc write posted during bridge hold");
    a_rate_restart: assert property (
        s_rate_change |=> tmr.restart ##1 !refreshReq)
        else $error("rate change did not restart timer");
    a_buf_reserved: assert property (
        (bufCtrl_q & ~dbc_pkg::BUF_CTRL_WMASK)
        == (dbc_pkg::BUF_CTRL_RST & ~dbc_pkg::BUF_CTRL_WMASK))
        else $error("reserved buffer control bits changed");
    a_pm_follow: assert property (
        modeCtrl_q[dbc_pkg::SDRAM_PM_BIT] != sdramPmActive
        |=> sdramPmActive == $past(modeCtrl_q[dbc_pkg::SDRAM_PM_BIT]))
        else $error("power management not following enable");
    a_buf_read: assert property (
        addrValid && !hwrite && haddr[11:0] == BUF_ADDR
        |=> hrdata == {24'h000000, bufCtrl_q})
        else $error("buffer control read data wrong");
    a_off_no_req: assert property (
        modeCtrl_q[2:0] == dbc_pkg::RATE_OFF |=> !refreshReq)
        else $error("refresh request with refresh off");
    a_row_write: assert property (
        wrPend_q && wrAddr_q == ROW_ADDR
        |=> rowMap_q == $past(hwdata[15:0]))
        else $error("row type map write lost");
    a_mode_reserved: assert property (
        (modeCtrl_q & ~dbc_pkg::MODE_CTRL_WMASK)
        == (dbc_pkg::MODE_CTRL_RST & ~dbc_pkg::MODE_CTRL_WMASK))
        else $error("reserved mode control bits changed");
endmodule : dbc_config_regs

/* hw/dbc_pkg.sv */
/*
 * dbc_pkg: register map, field layout, reset values and refresh timing
 * for the buffer, row type and dram mode configuration bank.
 * assumes a single 20 MHz core clock and a word-wide register bus.
 */
package dbc_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] BUF_CTRL_IDX = 8'h53;
    localparam logic [7:0] ROW_TYPE_IDX = 8'h55;
    localparam logic [7:0] MODE_CTRL_IDX = 8'h57;
    localparam logic [7:0] CHIP_CFG_IDX = 8'h50;
    localparam logic [7:0] STATUS_IDX = 8'h5c;

    // buffer posting control
    localparam logic [7:0] BUF_CTRL_RST = 8'h83;
    localparam logic [7:0] BUF_CTRL_WMASK = 8'h60;
    localparam int IDE_POST_BIT = 6;
    localparam int WC_HOLD_BIT = 5;

    // row type map, chipset configuration
    localparam logic [15:0] ROW_TYPE_RST = 16'h0000;
    localparam logic [15:0] CHIP_CFG_RST = 16'h0000;
    localparam int LONG_INTERVAL_BIT = 14;

    // dram mode control
    localparam logic [7:0] MODE_CTRL_RST = 8'h01;
    localparam logic [7:0] MODE_CTRL_WMASK = 8'h37;
    localparam int EDO_DETECT_BIT = 5;
    localparam int SDRAM_PM_BIT = 4;
    localparam logic [2:0] RATE_OFF = 3'h0;
    localparam logic [2:0] RATE_NORMAL = 3'h1;

    typedef enum logic [1:0] {
        ROW_EDO = 2'h0,
        ROW_RSVD = 2'h1,
        ROW_SDRAM = 2'h2,
        ROW_EMPTY = 2'h3
    } dbc_row_type_t;

    // refresh interval, counted in core clock cycles
    localparam int CLK_PERIOD_NS = 50;
    localparam int REFRESH_SHORT_NS = 15600;
    localparam int REFRESH_LONG_NS = 62400;
    localparam logic [11:0] REFRESH_SHORT_CYC =
        12'(REFRESH_SHORT_NS / CLK_PERIOD_NS);
    localparam logic [11:0] REFRESH_LONG_CYC =
        12'(REFRESH_LONG_NS / CLK_PERIOD_NS);

    function automatic logic [11:0] byteAddr(input logic [7:0] idx);
        return {2'h0, idx, 2'h0};
    endfunction : byteAddr

    function automatic dbc_row_type_t rowField(input logic [15:0] map,
                                               input logic [2:0] row);
        return dbc_row_type_t'(map[{row, 1'b0} +: 2]);
    endfunction : rowField

endpackage : dbc_pkg

/* hw/dbc_refresh_if.sv */
/*
 * dbc_refresh_if: control and request lines between the register bank
 * and its refresh interval timer. assumes both ends on core_clk.
 */
`timescale 1ns/1ps
interface dbc_refresh_if;
    logic run;
    logic longSel;
    logic restart;
    logic req;
    modport ctrl(output run, output longSel, output restart, input req);
    modport timer(input run, input longSel, input restart, output req);
endinterface : dbc_refresh_if

/* hw/dbc_refresh_timer.sv */
/*
 * dbc_refresh_timer: counts the refresh interval and pulses a request.
 * assumes run, longSel and restart come from flops on core_clk.
 */
`timescale 1ns/1ps
module dbc_refresh_timer (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // control and request
    dbc_refresh_if.timer tmr
);
    logic [11:0] count_q, count_d;
    logic req_q, req_d;
    logic [11:0] load;

    assign load = tmr.longSel ? dbc_pkg::REFRESH_LONG_CYC - 12'h001
                              : dbc_pkg::REFRESH_SHORT_CYC - 12'h001;
    assign tmr.req = req_q;

    always_comb begin
        count_d = count_q - 12'h001;
        req_d = 1'b0;
        if (tmr.restart || !tmr.run) begin
            count_d = load;
        end else if (count_q == 12'h000) begin
            count_d = load;
            req_d = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            count_q <= dbc_pkg::REFRESH_SHORT_CYC - 12'h001;
            req_q <= 1'b0;
        end else begin
            count_q <= count_d;
            req_q <= req_d;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_refresh_off_quiet: assert property (
        !tmr.run |=> !tmr.req)
        else $error("refresh request while refresh is off");
    a_interval_reload: assert property (
        tmr.restart && tmr.run && !tmr.longSel
        |=> count_q == dbc_pkg::REFRESH_SHORT_CYC - 12'h001)
        else $error("short interval not loaded on restart");
    a_long_reload: assert property (
        tmr.restart && tmr.run && tmr.longSel
        |=> count_q == dbc_pkg::REFRESH_LONG_CYC - 12'h001 ##1 !tmr.req)
        else $error("long interval not loaded on restart");
endmodule : dbc_refresh_timer

/* hw/dbc_row_lookup.sv */
/*
 * dbc_row_lookup: picks the memory type of the row a dram cycle targets
 * and hands the timing class on to the sequencer one cycle later.
 * assumes cycle requests come from logic on core_clk.
 */
`timescale 1ns/1ps
module dbc_row_lookup (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // configuration
    input wire logic [15:0] rowMap,
    input wire logic edoDetect,
    // cycle request
    input wire logic cycleReq,
    input wire logic [2:0] cycleRow,
    // cycle grant
    output logic cycleGo,
    output dbc_pkg::dbc_row_type_t cycleType,
    output logic edoProbe
);
    logic go_q, go_d, probe_q, probe_d;
    dbc_pkg::dbc_row_type_t type_q, type_d, expType;

    assign expType = dbc_pkg::rowField(rowMap, cycleRow);

    always_comb begin
        go_d = cycleReq;
        type_d = cycleReq ? expType : type_q;
        probe_d = cycleReq && edoDetect;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            go_q <= 1'b0;
            type_q <= dbc_pkg::ROW_EDO;
            probe_q <= 1'b0;
        end else begin
            go_q <= go_d;
            type_q <= type_d;
            probe_q <= probe_d;
        end
    end

    assign cycleGo = go_q;
    assign cycleType = type_q;
    assign edoProbe = probe_q;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_row_type_sel: assert property (
        cycleReq |=> cycleGo && cycleType == $past(expType))
        else $error("row timing class does not match row map");
    a_edo_probe_on: assert property (
        cycleReq |=> edoProbe == $past(edoDetect))
        else $error("edo detect timing not applied");
endmodule : dbc_row_lookup

/* testbench/dram_buffer_config_regs_bench.sv */
/*
 * dram_buffer_config_regs_bench: self-checking bench for dbc_config_regs,
 * register access over ahb-lite plus host write, lookup and refresh ports.
 * assumes the slave has zero wait states and hready is tied to hreadyout.
 */
`timescale 1ns/1ps
module dram_buffer_config_regs_bench;
    logic core_clk;
    logic rst_n;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    wire logic hready;
    logic hreadyout;
    logic [31:0] hrdata;
    logic hresp;
    logic ideWrReq;
    logic wcWrReq;
    logic idePosted;
    logic ideNonPosted;
    logic wcPosted;
    logic wcHeld;
    logic bridgeHoldAck_n;
    logic cycleReq;
    logic [2:0] cycleRow;
    logic cycleGo;
    logic [1:0] cycleType;
    logic edoProbe;
    logic sdramPmActive;
    logic refreshReq;
    int err_total;
    int cmp_count;
    int refCount;
    int n;
    int r;

    assign hready = hreadyout;

    dbc_config_regs u_dut (
        .core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .ideWrReq(ideWrReq), .wcWrReq(wcWrReq),
        .idePosted(idePosted), .ideNonPosted(ideNonPosted),
        .wcPosted(wcPosted), .wcHeld(wcHeld),
        .bridgeHoldAck_n(bridgeHoldAck_n), .cycleReq(cycleReq),
        .cycleRow(cycleRow), .cycleGo(cycleGo), .cycleType(cycleType),
        .edoProbe(edoProbe), .sdramPmActive(sdramPmActive),
        .refreshReq(refreshReq)
    );

    always #25 core_clk = ~core_clk;

    always @(posedge core_clk) begin
        if (refreshReq === 1'b1) begin
            refCount <= refCount + 1;
        end
    end

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // waits for hready at a rising edge; a hang ends the run
    task automatic wait_ready;
        int k;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (hready !== 1'b1 && k < 50);
        if (k >= 50) begin
            err_total++;
            print_verdict();
        end
    endtask : wait_ready

    task automatic bus_write(input logic [31:0] a, input logic [31:0] d);
        @(posedge core_clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= 1'b1;
        wait_ready();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        wait_ready();
    endtask : bus_write

    task automatic bus_read(input logic [31:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= 1'b0;
        wait_ready();
        htrans <= 2'h0;
        hsel <= 1'b0;
        wait_ready();
        check("hrdata", exp, hrdata);
        check("hresp", 32'h0, {31'h0, hresp});
    endtask : bus_read

    // one host write request, answer checked one cycle later
    task automatic host_wr(input logic wc, input logic [3:0] exp);
        @(posedge core_clk);
        ideWrReq <= ~wc;
        wcWrReq <= wc;
        @(posedge core_clk);
        ideWrReq <= 1'b0;
        wcWrReq <= 1'b0;
        #1;
        check("post", {28'h0, exp},
              {28'h0, idePosted, ideNonPosted, wcPosted, wcHeld});
    endtask : host_wr

    task automatic lookup(input logic [2:0] row, input logic [1:0] ty,
                          input logic probe);
        @(posedge core_clk);
        cycleReq <= 1'b1;
        cycleRow <= row;
        @(posedge core_clk);
        cycleReq <= 1'b0;
        #1;
        check("lookup", {28'h0, 1'b1, ty, probe},
              {28'h0, cycleGo, cycleType, edoProbe});
    endtask : lookup

    // cycles from now until a refresh request is sampled
    task automatic time_refresh(output int cyc);
        cyc = 0;
        do begin
            @(posedge core_clk);
            cyc++;
        end while (refreshReq !== 1'b1 && cyc < 2000);
    endtask : time_refresh

    initial begin
        core_clk = 1'b0;
        rst_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        ideWrReq = 1'b0;
        wcWrReq = 1'b0;
        bridgeHoldAck_n = 1'b1;
        cycleReq = 1'b0;
        cycleRow = 3'h0;
        err_total = 0;
        cmp_count = 0;
        refCount = 0;
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;

        bus_read(32'h0000014c, 32'h00000083);
        bus_read(32'h00000154, 32'h00000000);
        bus_read(32'h0000015c, 32'h00000001);
        bus_read(32'h00000200, 32'h00000000);
        $display("test reset_values done");

        host_wr(1'b0, 4'h4);
        host_wr(1'b1, 4'h2);
        bridgeHoldAck_n <= 1'b0;
        repeat (4) @(posedge core_clk);
        host_wr(1'b1, 4'h1);
        bus_write(32'h0000014c, 32'hffffffff);
        bus_read(32'h0000014c, 32'h000000e3);
        host_wr(1'b0, 4'h8);
        host_wr(1'b1, 4'h2);
        bus_write(32'h0000014c, 32'h00000000);
        host_wr(1'b0, 4'h4);
        host_wr(1'b1, 4'h1);
        bridgeHoldAck_n <= 1'b1;
        $display("test posting done");

        // legal types in turn, so a wrong row or bit pair shows up;
        // the reserved row and rate codes are never written
        bus_write(32'h00000154, 32'h00008e38);
        bus_read(32'h00000154, 32'h00008e38);
        bus_write(32'h0000015c, 32'hfffffff9);
        bus_read(32'h0000015c, 32'h00000031);
        bus_write(32'h0000015c, 32'h00000031);
        repeat (2) @(posedge core_clk);
        check("sdramPm", 32'h1, {31'h0, sdramPmActive});
        for (r = 0; r < 8; r++) begin
            lookup(3'(r), 2'(r % 3 == 0 ? 0 : r % 3 + 1), 1'b1);
        end
        bus_write(32'h0000015c, 32'h00000001);
        lookup(3'h7, 2'h2, 1'b0);
        repeat (2) @(posedge core_clk);
        check("sdramPm", 32'h0, {31'h0, sdramPmActive});
        $display("test row_mode done");

        // off first, so the later restart starts from a known point
        bus_write(32'h0000015c, 32'h00000000);
        repeat (2) @(posedge core_clk);
        n = refCount;
        repeat (400) @(posedge core_clk);
        check("refOff", 32'(n), 32'(refCount));
        bus_write(32'h0000015c, 32'h00000001);
        time_refresh(n);
        check("refShort", 32'h1, {31'h0, n >= 311 && n <= 316});
        bus_write(32'h00000140, 32'h00004000);
        bus_write(32'h0000015c, 32'h00000000);
        bus_write(32'h0000015c, 32'h00000001);
        time_refresh(n);
        check("refLong", 32'h1, {31'h0, n >= 1247 && n <= 1252});
        $display("test refresh done");
        print_verdict();
    end

    initial begin
        #(50 * 20000);
        err_total++;
        print_verdict();
    end
endmodule : dram_buffer_config_regs_bench
